// ==== include/xops_params.svh ====
/*
 Constants for the extended rotate, subtract, skip, set and swap datapath.
 Assumes inclusion by bare name from the design files.
*/
`ifndef XOPS_PARAMS_SVH
`define XOPS_PARAMS_SVH
`define XOPS_DATA_W 8
`define XOPS_ADDR_W 15
`define XOPS_OPC_W 5
`define XOPS_MSB 7
`define XOPS_NIB_HI 7:4
`define XOPS_NIB_LO 3:0
`define XOPS_HALF_MSB 3
`define XOPS_ALL_ONES 8'hFF
`define XOPS_ZERO 8'h00
`define XOPS_ONE 8'h01
`define XOPS_ACC_RST 8'h00
`define XOPS_ADDR_RST 15'h0000
`endif

// ==== include/xops_pkg.sv ====
/*
 Types for the extended operation datapath: opcodes and sequencer states.
 Assumes the params header is compiled alongside.
*/
package xops_pkg;
   typedef enum logic [4:0] {
      op_nop,
      rotl_thru_carry_to_accum,
      rotr_mem,
      rotr_to_accum,
      rotr_thru_carry_mem,
      rotr_thru_carry_to_accum,
      sub_borrow_to_accum,
      sub_borrow_to_mem,
      sub_to_accum,
      sub_to_mem,
      dec_skip_zero_mem,
      dec_skip_zero_accum,
      inc_skip_zero_mem,
      inc_skip_zero_accum,
      set_all_ones,
      set_bit,
      skip_nonzero,
      skip_nonzero_bit,
      skip_zero,
      skip_zero_bit,
      move_skip_zero,
      nibble_exchange_mem,
      nibble_exchange_accum
   } xop_e;
   typedef enum logic [1:0] {st_idle, st_exec, st_dummy} seq_e;
endpackage : xops_pkg

// ==== include/xops_res_if.sv ====
/*
 Interface carrying a computed result from the ALU module to the sequencer.
 Assumes one clock domain; purely combinational signals.
*/
`timescale 1ns/1ps
interface xops_res_if;
   logic [7:0] value;
   logic carry;
   logic arith_wrap;
   logic half_carry;
   logic signed_res;
   logic zero;
   logic chained_zero;
   logic to_mem;
   logic to_accum;
   logic flags_arith;
   logic carry_only;
   logic skip;
   modport alu (output value, carry, arith_wrap, half_carry, signed_res, zero, chained_zero,
      to_mem, to_accum, flags_arith, carry_only, skip);
   modport seq (input value, carry, arith_wrap, half_carry, signed_res, zero, chained_zero,
      to_mem, to_accum, flags_arith, carry_only, skip);
endinterface : xops_res_if

// ==== testbench/xops_core_checker.sv ====
/*
 Port checker for the extended operation sequencer.
 Assumes read data is held from the cycle after issue until retire.
*/
`timescale 1ns/1ps
module xops_core_checker (
   input wire logic ref_clk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic issue, // Offer
   input wire xops_pkg::xop_e issue_op, // Opcode
   input wire logic [14:0] issue_addr, // Address
   input wire logic [2:0] issue_bit, // Bit index
   input wire logic [7:0] mem_rdata, // Read data
   input wire logic ready, // Idle
   input wire logic mem_we, // Write strobe
   input wire logic [14:0] mem_addr, // Memory address
   input wire logic [7:0] mem_wdata, // Write data
   input wire logic [7:0] accum, // Accumulator
   input wire logic carry_flag, // Carry
   input wire logic zero_flag, // Zero
   input wire logic nop_out, // Squash
   input wire logic done // Retire
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire logic take = issue && ready;
   sequence s_fast;
      done && !nop_out;
   endsequence
   sequence s_slow;
      !done && !ready ##1 done && nop_out;
   endsequence
   a_retire_timing:
      assert property (take |=> !ready ##1 (s_fast or s_slow)) else $error("retire timing");
   a_squash_retire:
      assert property (nop_out |-> done && ready) else $error("squash without retire");
   a_addr_direct:
      assert property (take |=> mem_addr == $past(issue_addr)) else $error("address lost");
   a_set_ones:
      assert property (take && issue_op == xops_pkg::set_all_ones |=> ##1 mem_we
         && mem_wdata == 8'hFF) else $error("byte set wrong");
   a_rotr_wrap:
      assert property (take && issue_op == xops_pkg::rotr_mem |=> ##1 mem_we
         && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) else $error("rotr");
   a_swap_accum:
      assert property (take && issue_op == xops_pkg::nibble_exchange_accum |=> ##1 !mem_we
         && accum == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) else $error("swap");
   a_rot_noflag:
      assert property (take && issue_op == xops_pkg::rotr_to_accum |=> ##1
         $stable(carry_flag) && !mem_we) else $error("rotate touched flag");
   a_sub_carry:
      assert property (take && issue_op == xops_pkg::sub_to_accum |=> ##1
         carry_flag == ($past(accum) >= $past(mem_rdata))) else $error("sub carry");
   a_zero_skip:
      assert property (take && issue_op == xops_pkg::skip_zero ##1 mem_rdata == 8'h00
         |=> ##1 nop_out) else $error("zero skip missed");
   a_bit_set:
      assert property (take && issue_op == xops_pkg::set_bit |=> ##1 mem_we && mem_wdata
         == ($past(mem_rdata) | (8'h01 << $past(issue_bit, 2)))) else $error("bit set");
endmodule : xops_core_checker

bind xops_core xops_core_checker xops_core_checker_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .issue(issue), .issue_op(issue_op), .issue_addr(issue_addr), .issue_bit(issue_bit),
   .mem_rdata(mem_rdata), .ready(ready), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .accum(accum), .carry_flag(carry_flag), .zero_flag(zero_flag),
   .nop_out(nop_out), .done(done));

// ==== testbench/xops_core_tb.sv ====
/*
 Self-checking bench for the extended operation sequencer.
 Assumes the bench plays fetch unit and memory, holding read data per instruction.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module xops_core_tb;
   logic ref_clk = 1'b0, rst_b = 1'b0, issue = 1'b0;
   xops_pkg::xop_e issue_op = xops_pkg::op_nop;
   logic [14:0] issue_addr = 15'h0000, mem_addr;
   logic [2:0] issue_bit = 3'h0;
   logic [7:0] mem_rdata = 8'h00, mem_wdata, accum, wd;
   logic ready, mem_we, carry_flag, zero_flag, ovf, hcf, srf, czf, nop_out, done, we_seen, skp;
   int failures = 0, compares = 0, cycles = 0;
   xops_core xops_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .issue(issue),
      .issue_op(issue_op), .issue_addr(issue_addr), .issue_bit(issue_bit),
      .mem_rdata(mem_rdata), .ready(ready), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .accum(accum), .carry_flag(carry_flag), .zero_flag(zero_flag),
      .arith_wrap_flag(ovf), .half_carry_flag(hcf), .signed_result_flag(srf),
      .chained_zero_flag(czf), .nop_out(nop_out), .done(done));
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   // A hang is cut off well past the roughly eighty cycles the tests need.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         failures++;
         summarize();
      end
   end
   task automatic summarize;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // Entered at 1 ns past an edge; the request lands 10 ns past it.
   task automatic exec(input xops_pkg::xop_e op, input logic [14:0] a, input logic [2:0] b,
      input logic [7:0] m, input logic exp_skip);
      int n;
      #9;
      issue = 1'b1;
      issue_op = op;
      issue_addr = a;
      issue_bit = b;
      mem_rdata = m;
      @(posedge ref_clk);
      #10;
      issue = 1'b0;
      we_seen = 1'b0;
      skp = 1'b0;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n++;
         if (mem_we === 1'b1)
         begin
            we_seen = 1'b1;
            wd = mem_wdata;
         end
         if (nop_out === 1'b1)
            skp = 1'b1;
      end while (done !== 1'b1 && n < 6);
      `CHK("latency", (exp_skip ? 2 : 1), n)
      `CHK("squash", exp_skip, skp)
      `CHK("address", a, mem_addr)
   endtask : exec
   task automatic t_rotate;
      exec(xops_pkg::rotr_thru_carry_to_accum, 15'h0001, 3'h0, 8'h01, 1'b0);
      `CHK("rrca acc", 8'h00, accum)
      `CHK("rrca carry", 1'b1, carry_flag)
      exec(xops_pkg::rotl_thru_carry_to_accum, 15'h4000, 3'h0, 8'h80, 1'b0);
      `CHK("rlca acc", 8'h01, accum)
      `CHK("rlca we", 1'b0, we_seen)
      exec(xops_pkg::rotr_mem, 15'h7FFF, 3'h0, 8'h01, 1'b0);
      `CHK("rr data", 8'h80, wd)
      `CHK("rr carry", 1'b1, carry_flag)
      exec(xops_pkg::rotr_to_accum, 15'h0123, 3'h0, 8'h02, 1'b0);
      `CHK("rra acc", 8'h01, accum)
      exec(xops_pkg::rotr_thru_carry_mem, 15'h5555, 3'h0, 8'h00, 1'b0);
      `CHK("rrc data", 8'h80, wd)
      `CHK("rrc carry", 1'b0, carry_flag)
      $display("rotate test done");
   endtask : t_rotate
   task automatic t_subtract;
      exec(xops_pkg::move_skip_zero, 15'h2345, 3'h0, 8'h00, 1'b1);
      exec(xops_pkg::move_skip_zero, 15'h2345, 3'h0, 8'h50, 1'b0);
      `CHK("move acc", 8'h50, accum)
      exec(xops_pkg::sub_to_accum, 15'h0800, 3'h0, 8'h60, 1'b0);
      `CHK("sub acc", 8'hF0, accum)
      `CHK("sub flags", 5'b00110, {carry_flag, ovf, hcf, srf, zero_flag})
      exec(xops_pkg::sub_borrow_to_mem, 15'h0801, 3'h0, 8'h70, 1'b0);
      `CHK("sbcm data", 8'h7F, wd)
      `CHK("sbcm flags", 5'b11010, {carry_flag, ovf, hcf, srf, zero_flag})
      exec(xops_pkg::sub_to_mem, 15'h0802, 3'h0, 8'hF0, 1'b0);
      `CHK("subm zero", 3'b110, {carry_flag, zero_flag, czf})
      exec(xops_pkg::sub_borrow_to_accum, 15'h0803, 3'h0, 8'hF0, 1'b0);
      `CHK("sbc chain", 11'h007, {accum, carry_flag, zero_flag, czf})
      $display("subtract test done");
   endtask : t_subtract
   task automatic t_skip_count;
      exec(xops_pkg::dec_skip_zero_mem, 15'h1000, 3'h0, 8'h01, 1'b1);
      `CHK("dec data", 9'h100, {we_seen, wd})
      exec(xops_pkg::dec_skip_zero_mem, 15'h1001, 3'h0, 8'h02, 1'b0);
      `CHK("dec data", 8'h01, wd)
      exec(xops_pkg::inc_skip_zero_mem, 15'h1002, 3'h0, 8'hFF, 1'b1);
      `CHK("inc data", 8'h00, wd)
      `CHK("inc flags", 2'b11, {carry_flag, zero_flag})
      exec(xops_pkg::dec_skip_zero_accum, 15'h1003, 3'h0, 8'h01, 1'b1);
      `CHK("deca", 9'h000, {we_seen, accum})
      exec(xops_pkg::inc_skip_zero_accum, 15'h1004, 3'h0, 8'h10, 1'b0);
      `CHK("inca", 9'h011, {we_seen, accum})
      $display("count skip test done");
   endtask : t_skip_count
   task automatic t_skip_test;
      xops_pkg::xop_e ops[8] = '{xops_pkg::skip_zero, xops_pkg::skip_zero,
         xops_pkg::skip_nonzero, xops_pkg::skip_nonzero, xops_pkg::skip_zero_bit,
         xops_pkg::skip_zero_bit, xops_pkg::skip_nonzero_bit, xops_pkg::skip_nonzero_bit};
      logic [7:0] ms[8] = '{8'h00, 8'h05, 8'h05, 8'h00, 8'hF7, 8'h08, 8'h08, 8'hF7};
      logic sk[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int k = 0; k < 8; k++)
      begin
         exec(ops[k], 15'h6000, 3'h3, ms[k], sk[k]);
         `CHK("test we", 1'b0, we_seen)
      end
      `CHK("test flags", 2'b11, {carry_flag, zero_flag})
      $display("test skip test done");
   endtask : t_skip_test
   task automatic t_set_swap;
      exec(xops_pkg::set_all_ones, 15'h3000, 3'h0, 8'h12, 1'b0);
      `CHK("set data", 8'hFF, wd)
      exec(xops_pkg::set_bit, 15'h3001, 3'h7, 8'h01, 1'b0);
      `CHK("bit7 data", 8'h81, wd)
      exec(xops_pkg::set_bit, 15'h3002, 3'h0, 8'h80, 1'b0);
      `CHK("bit0 data", 8'h81, wd)
      exec(xops_pkg::nibble_exchange_mem, 15'h3003, 3'h0, 8'hA5, 1'b0);
      `CHK("swap data", 9'h15A, {we_seen, wd})
      exec(xops_pkg::nibble_exchange_accum, 15'h3004, 3'h0, 8'h3C, 1'b0);
      `CHK("swapa", 9'h0C3, {we_seen, accum})
      `CHK("swap flags", 2'b11, {carry_flag, zero_flag})
      $display("set and swap test done");
   endtask : t_set_swap
   initial
   begin
      repeat (12) @(posedge ref_clk);
      `CHK("reset ready", 9'h100, {ready, accum})
      #10;
      rst_b = 1'b1;
      @(posedge ref_clk);
      #1;
      t_rotate();
      t_subtract();
      t_skip_count();
      t_skip_test();
      t_set_swap();
      summarize();
   end
endmodule : xops_core_tb

// ==== verilog/xops_alu.sv ====
/*
 Combinational result unit for the extended operations.
 Assumes operands are stable for the execute cycle.
*/
`timescale 1ns/1ps
`include "xops_params.svh"
module xops_alu (
   input wire xops_pkg::xop_e op, // Operation being executed
   input wire logic [7:0] mem_val, // Memory operand
   input wire logic [7:0] acc_val, // Accumulator
   input wire logic [2:0] bit_sel, // Bit index i
   input wire logic carry_in, // Current carry
   input wire logic zero_in, // Current zero flag, for chaining
   xops_res_if.alu res // Result bundle
);
   logic [8:0] diff;
   logic [4:0] hdiff;
   logic borrow;
   logic [7:0] v;

   always_comb
   begin
      borrow = (op == xops_pkg::sub_borrow_to_accum || op == xops_pkg::sub_borrow_to_mem)
         ? ~carry_in : 1'b0;
      diff = {1'b0, acc_val} - {1'b0, mem_val} - {8'h00, borrow};
      hdiff = {1'b0, acc_val[`XOPS_NIB_LO]} - {1'b0, mem_val[`XOPS_NIB_LO]} - {4'h0, borrow};
      v = mem_val;
      res.carry = carry_in;
      res.to_mem = 1'b0;
      res.to_accum = 1'b0;
      res.flags_arith = 1'b0;
      res.carry_only = 1'b0;
      res.skip = 1'b0;
      case (op)
         xops_pkg::rotl_thru_carry_to_accum:
         begin
            v = {mem_val[6:0], carry_in};
            res.carry = mem_val[`XOPS_MSB];
            res.to_accum = 1'b1;
            res.carry_only = 1'b1;
         end
         xops_pkg::rotr_mem:
         begin
            v = {mem_val[0], mem_val[7:1]};
            res.to_mem = 1'b1;
         end
         xops_pkg::rotr_to_accum:
         begin
            v = {mem_val[0], mem_val[7:1]};
            res.to_accum = 1'b1;
         end
         xops_pkg::rotr_thru_carry_mem, xops_pkg::rotr_thru_carry_to_accum:
         begin
            v = {carry_in, mem_val[7:1]};
            res.carry = mem_val[0];
            res.carry_only = 1'b1;
            res.to_mem = (op == xops_pkg::rotr_thru_carry_mem);
            res.to_accum = (op == xops_pkg::rotr_thru_carry_to_accum);
         end
         xops_pkg::sub_borrow_to_accum, xops_pkg::sub_borrow_to_mem,
         xops_pkg::sub_to_accum, xops_pkg::sub_to_mem:
         begin
            v = diff[7:0];
            res.carry = ~diff[8];
            res.flags_arith = 1'b1;
            res.to_mem = (op == xops_pkg::sub_borrow_to_mem || op == xops_pkg::sub_to_mem);
            res.to_accum = ~res.to_mem;
         end
         xops_pkg::dec_skip_zero_mem, xops_pkg::dec_skip_zero_accum:
         begin
            v = mem_val - `XOPS_ONE;
            res.skip = (v == `XOPS_ZERO);
            res.to_mem = (op == xops_pkg::dec_skip_zero_mem);
            res.to_accum = (op == xops_pkg::dec_skip_zero_accum);
         end
         xops_pkg::inc_skip_zero_mem, xops_pkg::inc_skip_zero_accum:
         begin
            v = mem_val + `XOPS_ONE;
            res.skip = (v == `XOPS_ZERO);
            res.to_mem = (op == xops_pkg::inc_skip_zero_mem);
            res.to_accum = (op == xops_pkg::inc_skip_zero_accum);
         end
         xops_pkg::set_all_ones:
         begin
            v = `XOPS_ALL_ONES;
            res.to_mem = 1'b1;
         end
         xops_pkg::set_bit:
         begin
            v = mem_val | (`XOPS_ONE << bit_sel);
            res.to_mem = 1'b1;
         end
         xops_pkg::skip_nonzero:
            res.skip = (mem_val != `XOPS_ZERO);
         xops_pkg::skip_nonzero_bit:
            res.skip = mem_val[bit_sel];
         xops_pkg::skip_zero:
            res.skip = (mem_val == `XOPS_ZERO);
         xops_pkg::skip_zero_bit:
            res.skip = ~mem_val[bit_sel];
         xops_pkg::move_skip_zero:
         begin
            res.skip = (mem_val == `XOPS_ZERO);
            res.to_accum = 1'b1;
         end
         xops_pkg::nibble_exchange_mem, xops_pkg::nibble_exchange_accum:
         begin
            v = {mem_val[`XOPS_NIB_LO], mem_val[`XOPS_NIB_HI]};
            res.to_mem = (op == xops_pkg::nibble_exchange_mem);
            res.to_accum = (op == xops_pkg::nibble_exchange_accum);
         end
         default:
            v = mem_val;
      endcase
      res.value = v;
      res.zero = (v == `XOPS_ZERO);
      res.chained_zero = (v == `XOPS_ZERO) & zero_in;
      res.half_carry = ~hdiff[4];
      res.arith_wrap = (acc_val[`XOPS_MSB] ^ mem_val[`XOPS_MSB])
         & (acc_val[`XOPS_MSB] ^ diff[`XOPS_MSB]);
      res.signed_res = diff[`XOPS_MSB] ^ res.arith_wrap;
   end
endmodule : xops_alu

// ==== verilog/xops_core.sv ====
/*
 Extended-operation sequencer: rotate, subtract, skip, set and swap over full
 data memory addresses. Assumes a synchronous data memory port where read data
 is valid one cycle after the address is presented, and a fetch unit that
 offers one instruction per issue strobe.
*/
// Overview of operation
// - Rotate left through carry into accumulator; carry from bit 7, memory untouched.
// - Rotate memory right, bit 0 wraps to bit 7, no flags.
// - Rotate right into accumulator, memory intact, no flags.
// - Rotate right through carry to memory or accumulator; only carry changes.
// - Subtract with borrow: acc minus mem minus inverted carry, six flags updated.
// - Subtraction carry is 0 when negative, 1 when zero or positive.
// - Subtract without borrow to accumulator or memory, same six flags.
// - Every conditional skip takes two instruction cycles when it skips, one when it does not.
// - Decrement memory, skip next when result zero, no flags.
// - Increment memory, skip next when result zero, no flags.
// - Accumulator forms of decrement/increment skip keep memory unchanged.
// - Byte set writes all ones, no flags.
// - Bit set forces bit i to one, keeps other bits.
// - Skip when byte or bit is nonzero, no flags.
// - Skip when byte or bit is zero, no flags.
// - Move byte to accumulator, skip when it is zero.
// - Swap memory nibbles in place, no flags.
// - Swap nibbles into accumulator, memory unchanged.
// - Any data memory address reached directly, no bank selection.
`timescale 1ns/1ps
`include "xops_params.svh"
module xops_core (
   input wire logic ref_clk, // Instruction clock, 10 MHz
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic issue, // Pulse: new instruction offered
   input wire xops_pkg::xop_e issue_op, // Operation code
   input wire logic [14:0] issue_addr, // Full data memory address
   input wire logic [2:0] issue_bit, // Bit index i
   input wire logic [7:0] mem_rdata, // Memory read data, one cycle after issue_addr
   output logic ready, // Sequencer can take an instruction
   output logic mem_we, // Memory write strobe
   output logic [14:0] mem_addr, // Memory address
   output logic [7:0] mem_wdata, // Memory write data
   output logic [7:0] accum, // Accumulator
   output logic carry_flag, // Carry
   output logic zero_flag, // Zero
   output logic arith_wrap_flag, // Overflow
   output logic half_carry_flag, // Half carry
   output logic signed_result_flag, // Signed compare
   output logic chained_zero_flag, // Chained zero
   output logic nop_out, // Pulse: fetched instruction squashed
   output logic done // Pulse: instruction retired
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   xops_pkg::seq_e state, next_state;
   xops_pkg::xop_e op, next_op;
   logic [2:0] bit_idx, next_bit_idx;
   logic next_ready, next_mem_we, next_nop_out, next_done;
   logic [14:0] next_mem_addr;
   logic [7:0] next_mem_wdata, next_accum;
   logic next_carry, next_zero, next_wrap, next_half, next_signed, next_chain;
   xops_res_if res ();

   xops_alu xops_alu_i (
      .op(op),
      .mem_val(mem_rdata),
      .acc_val(accum),
      .bit_sel(bit_idx),
      .carry_in(carry_flag),
      .zero_in(zero_flag),
      .res(res)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_op = op;
      next_bit_idx = bit_idx;
      next_ready = ready;
      next_mem_we = 1'b0;
      next_mem_addr = mem_addr;
      next_mem_wdata = mem_wdata;
      next_accum = accum;
      next_carry = carry_flag;
      next_zero = zero_flag;
      next_wrap = arith_wrap_flag;
      next_half = half_carry_flag;
      next_signed = signed_result_flag;
      next_chain = chained_zero_flag;
      next_nop_out = 1'b0;
      next_done = 1'b0;
      case (state)
         xops_pkg::st_idle:
            if (issue)
            begin
               next_op = issue_op;
               next_bit_idx = issue_bit;
               next_mem_addr = issue_addr;
               next_ready = 1'b0;
               next_state = xops_pkg::st_exec;
            end
         xops_pkg::st_exec:
         begin
            if (res.to_mem)
            begin
               next_mem_we = 1'b1;
               next_mem_wdata = res.value;
            end
            if (res.to_accum)
               next_accum = res.value;
            if (res.carry_only)
               next_carry = res.carry;
            if (res.flags_arith)
            begin
               next_carry = res.carry;
               next_zero = res.zero;
               next_wrap = res.arith_wrap;
               next_half = res.half_carry;
               next_signed = res.signed_res;
               next_chain = res.chained_zero;
            end
            if (res.skip)
               next_state = xops_pkg::st_dummy;
            else
            begin
               next_state = xops_pkg::st_idle;
               next_ready = 1'b1;
               next_done = 1'b1;
            end
         end
         xops_pkg::st_dummy:
         begin
            // The next instruction is already fetched; retiring it as a no-op costs a cycle.
            next_nop_out = 1'b1;
            next_done = 1'b1;
            next_ready = 1'b1;
            next_state = xops_pkg::st_idle;
         end
         default:
            next_state = xops_pkg::st_idle;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= xops_pkg::st_idle;
         op <= xops_pkg::op_nop;
         bit_idx <= 3'h0;
         ready <= 1'b1;
         mem_we <= 1'b0;
         mem_addr <= `XOPS_ADDR_RST;
         mem_wdata <= `XOPS_ZERO;
         accum <= `XOPS_ACC_RST;
         carry_flag <= 1'b0;
         zero_flag <= 1'b0;
         arith_wrap_flag <= 1'b0;
         half_carry_flag <= 1'b0;
         signed_result_flag <= 1'b0;
         chained_zero_flag <= 1'b0;
         nop_out <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         op <= next_op;
         bit_idx <= next_bit_idx;
         ready <= next_ready;
         mem_we <= next_mem_we;
         mem_addr <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
         accum <= next_accum;
         carry_flag <= next_carry;
         zero_flag <= next_zero;
         arith_wrap_flag <= next_wrap;
         half_carry_flag <= next_half;
         signed_result_flag <= next_signed;
         chained_zero_flag <= next_chain;
         nop_out <= next_nop_out;
         done <= next_done;
      end
   end
endmodule : xops_core
